/* File: bench/ssbc_host_model.sv */
`timescale 1ns/1ns
module ssbc_host_model
#(
  parameter int ADDR_W = 4 // Word address width
)
(
  input  wire logic                        clk,          // Clock
  output logic [ADDR_W-1:0]                addr,         // Word address
  output ssbc_pkg::ssbc_ctrl_t             ctrl,         // Enables
  output ssbc_pkg::ssbc_wr_t               wr,           // Writes
  output logic                             out_enable_n, // Output enable
  output logic [ssbc_pkg::DATA_W-1:0]      data_lane_in  // Lane data
);
  import ssbc_pkg::*;

  initial
  begin
    addr         = '0;
    ctrl         = 6'h17;
    wr           = 10'h3ff;
    out_enable_n = 1'b0;
    data_lane_in = '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // One bus cycle: all lines change after an edge and stand until the next.
  task automatic drive(input ssbc_ctrl_t c, input ssbc_wr_t w,
                       input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic oen);
    @(posedge clk);
    ctrl         <= c;
    wr           <= w;
    addr         <= a;
    out_enable_n <= oen;
    // Data is driven only with the controller strobe and a write line low; otherwise it is scrambled so stale values cannot pass.
    if (!c.ctrl_addr_strobe_n && (!w.write_all_n || !w.byte_write_gate_n))
      data_lane_in <= d;
    else
      data_lane_in <= ~data_lane_in;
  endtask : drive

endmodule : ssbc_host_model

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import ssbc_pkg::*;

  localparam int         AW     = 4;
  localparam ssbc_ctrl_t C_IDLE = 6'h17;
  localparam ssbc_ctrl_t C_BEG  = 6'h15;
  localparam ssbc_ctrl_t C_CPU  = 6'h13;
  localparam ssbc_ctrl_t C_ADV  = 6'h16;
  localparam ssbc_ctrl_t C_DES  = 6'h05;
  localparam ssbc_wr_t   W_RD   = 10'h3ff;

  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [AW-1:0]     addr;
  ssbc_ctrl_t        ctrl;
  ssbc_wr_t          wr;
  logic              oen;
  ssbc_mode_t        mode = MODE_DEFAULT;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] dout;
  logic [LANES-1:0]  oe;
  logic              high_drive;
  logic              standby;
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] exp_q [$];
  logic              oen_sel = 1'b0;
  int                error_cnt = 0;
  int                tests_run = 0;

  always #4 clk = ~clk;

  ssbc_top #(.ADDR_W(AW)) i_dut (.clk(clk), .srst(srst), .addr(addr),
    .ctrl(ctrl), .wr(wr), .out_enable_n(oen), .mode(mode),
    .data_lane_in(din), .data_lane_out(dout), .data_lane_oe(oe),
    .high_drive(high_drive), .standby(standby));

  ssbc_host_model #(.ADDR_W(AW)) i_host (.clk(clk), .addr(addr),
    .ctrl(ctrl), .wr(wr), .out_enable_n(oen), .data_lane_in(din));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic tick(input ssbc_ctrl_t c, input ssbc_wr_t w,
                      input logic [AW-1:0] a, input logic [DATA_W-1:0] d);
    i_host.drive(c, w, a, d, oen_sel);
  endtask : tick

  function automatic logic [AW-1:0] beat(input logic [AW-1:0] a,
                                         input int k, input bit lin);
    logic [1:0] s;
    s = lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
    return {a[AW-1:2], s};
  endfunction : beat

  task automatic wr_word(input logic [AW-1:0] a, input ssbc_wr_t w,
                         input bit store);
    logic [DATA_W-1:0] d;
    d = DATA_W'({$urandom, $urandom, $urandom});
    tick(C_BEG, w, a, d);
    for (int i = 0; i < LANES; i++)
      if (store && (!w.write_all_n ||
          (!w.byte_write_gate_n && !w.lane_write_n[i])))
        mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
  endtask : wr_word

  // Read burst of n beats, optional hold after the first, then deselect;
  // drop removes results that the deselect, output enable high or standby cuts off.
  task automatic rd_burst(input logic [AW-1:0] a, input int n,
                          input bit lin, input bit susp, input int drop);
    tick(C_BEG, {2'b11, 8'($urandom)}, a, '0);
    exp_q.push_back(mem[a]);
    if (susp)
    begin
      tick(C_IDLE, W_RD, '0, '0);
      exp_q.push_back(mem[a]);
    end
    for (int k = 1; k < n; k++)
    begin
      tick(C_ADV, W_RD, '0, '0);
      exp_q.push_back(mem[beat(a, k, lin)]);
    end
    tick(C_DES, W_RD, '0, '0);
    repeat (drop) void'(exp_q.pop_back());
    repeat (3) tick(C_IDLE, W_RD, '0, '0);
  endtask : rd_burst

  task automatic set_mode(input logic [4:0] m);
    @(posedge clk);
    mode <= m;
    repeat (4) tick(C_IDLE, W_RD, '0, '0);
    #1;
    check(DATA_W'(high_drive), DATA_W'(!m[0]));
    check(DATA_W'(standby), DATA_W'(m[2]));
  endtask : set_mode

  //////////////////////////////////////////////////////////////////////////
  // Every driven cycle must be announced; data is checked as one whole word.
  always @(posedge clk)
    if (!srst && oe !== 8'h00)
    begin
      if (exp_q.size() == 0)
        check(DATA_W'(oe), '0);
      else
      begin
        check(DATA_W'(oe), DATA_W'(8'hff));
        check(dout, exp_q.pop_front());
      end
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(72));
    repeat (19) @(posedge clk);
    #1;
    check(DATA_W'({oe, high_drive, standby}), '0);
    check(dout, '0);
    @(posedge clk);
    srst <= 1'b0;
    set_mode(5'b00010);
    for (int a = 0; a < 16; a++)
      wr_word(AW'(a), {1'b0, 9'($urandom)}, 1'b1);
    for (int a = 0; a < 16; a++)
      wr_word(AW'(a), {2'b10, (a == 5) ? 8'hff : 8'($urandom)}, 1'b1);
    tick(C_DES, W_RD, '0, '0);
    for (int i = 0; i < 3; i++)
      tick(ssbc_ctrl_t'(i == 0 ? 6'h35 : i == 1 ? 6'h05 : 6'h1d),
           10'h1ff, 4'h3, '1);
    tick(C_CPU, 10'h000, 4'h2, '1);
    exp_q.push_back(mem[2]);
    tick(C_DES, W_RD, '0, '0);
    tick(C_BEG, W_RD, 4'h7, '0);
    exp_q.push_back(mem[7]);
    wr_word(4'h8, 10'h0ff, 1'b1);
    tick(C_DES, W_RD, '0, '0);
    for (int lin = 1; lin >= 0; lin--)
    begin
      set_mode({1'(!lin), 4'b0010});
      for (int s = 0; s < 4; s++)
        rd_burst(AW'(5 * s), 5, 1'(lin), 1'b0, 0);
      rd_burst(4'h6, 3, 1'(lin), 1'b1, 0);
    end
    rd_burst(4'h2, 1, 1'b1, 1'b0, 0);
    rd_burst(4'h3, 1, 1'b1, 1'b0, 0);
    rd_burst(4'h8, 1, 1'b1, 1'b0, 0);
    set_mode(5'b01010);
    rd_burst(4'h9, 2, 1'b1, 1'b0, 1);
    set_mode(5'b01000);
    rd_burst(4'ha, 1, 1'b1, 1'b1, 0);
    oen_sel = 1'b1;
    rd_burst(4'hb, 1, 1'b1, 1'b1, 2);
    oen_sel = 1'b0;
    set_mode(5'b01110);
    wr_word(4'hc, 10'h000, 1'b0);
    rd_burst(4'hc, 1, 1'b1, 1'b1, 2);
    set_mode(5'b01011);
    rd_burst(4'hc, 1, 1'b1, 1'b1, 1);
    repeat (6) tick(C_IDLE, W_RD, '0, '0);
    check(DATA_W'(exp_q.size()), '0);
    report_and_stop();
  end

endmodule : testbench

/* File: rtl/ssbc_burst_ctr.sv */
`timescale 1ns/1ns
module ssbc_burst_ctr
(
  input  wire logic                            clk,        // Clock
  input  wire logic                            srst,       // Sync reset
  input  wire logic                            load,       // New address
  input  wire logic                            advance,    // Step count
  input  wire logic                            interleave, // Order select
  input  wire logic [ssbc_pkg::BURST_W-1:0]    start,      // Start LSBs
  output logic      [ssbc_pkg::BURST_W-1:0]    lsb_cur,    // Held LSBs
  output logic      [ssbc_pkg::BURST_W-1:0]    lsb_adv     // Next LSBs
);
  import ssbc_pkg::*;

  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] count_reg;
  logic [BURST_W-1:0] count_next;

  ////////////////////////////////////////////////////////////////////////////

  assign count_next = count_reg + BURST_CNT_STEP;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_reg <= BURST_CNT_START;
      count_reg <= BURST_CNT_START;
    end
    else if (load)
    begin
      start_reg <= start;
      count_reg <= BURST_CNT_START;
    end
    else if (advance)
    begin
      count_reg <= count_next;
    end
  end

  // Linear order adds the count, interleaved order exclusive-ORs it.
  assign lsb_cur = interleave ? (start_reg ^ count_reg)
                              : (start_reg + count_reg);
  assign lsb_adv = interleave ? (start_reg ^ count_next)
                              : (start_reg + count_next);

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_four_steps;
    (advance && !load)[*4];
  endsequence

  a_burst_wrap_fifth: assert property (
    s_four_steps |=> (lsb_cur == $past(lsb_cur, 4)))
    else $error("burst counter did not wrap after four steps");

  a_linear_step: assert property (
    (advance && !load && !interleave) ##1 !interleave
      |-> (lsb_cur == $past(lsb_cur) + BURST_CNT_STEP))
    else $error("linear burst did not add one");

  a_interleave_step: assert property (
    (advance && !load && interleave) ##1 interleave
      |-> ((lsb_cur ^ start_reg) == $past(count_next)))
    else $error("interleaved burst lost its xor pattern");

endmodule : ssbc_burst_ctr

/* File: rtl/ssbc_drive_ctl.sv */
`timescale 1ns/1ns
module ssbc_drive_ctl
(
  input  wire logic clk,        // Clock
  input  wire logic srst,       // Sync reset
  input  wire logic read_now,   // Read taken this cycle
  input  wire logic desel_now,  // Deselect taken this cycle
  input  wire logic pipelined,  // Output register in use
  input  wire logic dual_cycle, // Dual cycle deselect
  input  wire logic gate,       // Drivers allowed at all
  output logic      drive_reg   // Registered driver enable
);
  import ssbc_pkg::*;

  logic rd_q1_reg;
  logic drive_next;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (srst)
      rd_q1_reg <= 1'b0;
    else
      rd_q1_reg <= read_now;
  end

  // A single cycle deselect cuts the pipelined read one stage early.
  always_comb
  begin
    if (!pipelined)
      drive_next = read_now;
    else if (dual_cycle)
      drive_next = rd_q1_reg;
    else
      drive_next = rd_q1_reg && !desel_now;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      drive_reg <= 1'b0;
    else
      drive_reg <= drive_next && gate;
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_dcd_hold_cycle: assert property (
    (pipelined && dual_cycle && gate && rd_q1_reg && desel_now)
      |=> drive_reg)
    else $error("dual cycle deselect cut the last read short");

  a_scd_early_off: assert property (
    (pipelined && !dual_cycle && desel_now) |=> !drive_reg)
    else $error("single cycle deselect left drivers on");

endmodule : ssbc_drive_ctl

/* File: rtl/ssbc_pkg.sv */
package ssbc_pkg;

  localparam int LANES   = 8;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int ADDR_W_DEF = 10;

  // Counter value loaded with every new external address.
  localparam logic [BURST_W-1:0] BURST_CNT_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_CNT_STEP  = 2'h1;

  // Values the mode pins take while reset holds, as if left unconnected.
  localparam logic DEF_BURST_ORDER_LINEAR_N = 1'b1;
  localparam logic DEF_FLOW_THROUGH_N       = 1'b1;
  localparam logic DEF_SLEEP_REQ            = 1'b0;
  localparam logic DEF_DESELECT_MODE_SEL    = 1'b1;
  localparam logic DEF_DRIVE_STRENGTH_SEL   = 1'b1;

  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } ssbc_state_t;

  typedef struct packed {
    logic chip_sel_first_n;
    logic chip_sel_second;
    logic chip_sel_third_n;
    logic cpu_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
  } ssbc_ctrl_t;

  typedef struct packed {
    logic             write_all_n;
    logic             byte_write_gate_n;
    logic [LANES-1:0] lane_write_n;
  } ssbc_wr_t;

  typedef struct packed {
    logic burst_order_linear_n;
    logic flow_through_n;
    logic sleep_req;
    logic deselect_mode_sel;
    logic drive_strength_sel;
  } ssbc_mode_t;

  localparam ssbc_mode_t MODE_DEFAULT = '{
    burst_order_linear_n: DEF_BURST_ORDER_LINEAR_N,
    flow_through_n:       DEF_FLOW_THROUGH_N,
    sleep_req:            DEF_SLEEP_REQ,
    deselect_mode_sel:    DEF_DESELECT_MODE_SEL,
    drive_strength_sel:   DEF_DRIVE_STRENGTH_SEL
  };

endpackage : ssbc_pkg

/* File: rtl/ssbc_top.sv */
`timescale 1ns/1ns
// How it works
// - Every synchronous input is taken on the rising clock edge.
// - Selected only with second enable high, first and third low.
// - Both address strobes count as asserted when low.
// - Burst counter steps only when advance is sampled low.
// - New external address presets counter from the two address LSBs.
// - Linear order: start value, then plus one modulo four.
// - Interleaved order: start value xor burst count 0 to 3.
// - After four addresses the counter wraps to the start value.
// - Burst order pin low picks linear, high picks interleaved.
// - Output mode pin low is flow-through, high or open pipelined.
// - Sleep high means standby, low or open means active.
// - Deselect pin low is dual cycle, high or open single cycle.
// - Open drive, deselect and output pins read high, sleep low.
// - Global write low writes every lane, ignoring byte controls.
// - Byte gate low writes lanes whose lane write is low.
// - Global write and byte gate high make a read of all lanes.
// - Data lanes stay undriven during every write.
// - Lane write a through h maps onto data lane a through h.
// - Data drivers are on only while output enable is low.
// - Flow-through bypasses the output register, pipelined uses it.
// - In pipelined mode, dual cycle deselect holds one cycle before drivers turn off.
// - Output enable high turns drivers off; low only enables reads.
module ssbc_top
#(
  parameter int ADDR_W = ssbc_pkg::ADDR_W_DEF // Word address width
)
(
  input  wire logic                          clk,           // Clock
  input  wire logic                          srst,          // Sync reset
  input  wire logic [ADDR_W-1:0]             addr,          // Word address
  input  wire ssbc_pkg::ssbc_ctrl_t          ctrl,          // Enables
  input  wire ssbc_pkg::ssbc_wr_t            wr,            // Writes
  input  wire logic                          out_enable_n,  // Output enable
  input  wire ssbc_pkg::ssbc_mode_t          mode,          // Mode pins
  input  wire logic [ssbc_pkg::DATA_W-1:0]   data_lane_in,  // Lane input
  output logic      [ssbc_pkg::DATA_W-1:0]   data_lane_out, // Lane output
  output logic      [ssbc_pkg::LANES-1:0]    data_lane_oe,  // Lane enable
  output logic                               high_drive,    // Strong drive
  output logic                               standby        // In standby
);
  import ssbc_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  generate
    if (ADDR_W <= BURST_W || ADDR_W > 20)
    begin : g_bad_width
      $error("ADDR_W must lie between BURST_W+1 and 20");
    end
  endgenerate

  ssbc_mode_t         mode_reg;
  ssbc_state_t        state_reg;
  ssbc_state_t        state_next;
  logic [ADDR_W-1:0]  base_reg;
  logic [DATA_W-1:0]  rd_q1_reg;
  logic [DATA_W-1:0]  data_out_reg;
  logic               high_drive_reg;
  logic               standby_reg;
  logic [DATA_W-1:0]  mem [DEPTH];

  logic               sleeping;
  logic               pipelined;
  logic               dual_cycle;
  logic               interleave;
  logic               selected;
  logic               cpu_go;
  logic               ctrl_go;
  logic               begin_now;
  logic               desel_now;
  logic               cont_now;
  logic               adv_now;
  logic               write_req;
  logic               write_now;
  logic               read_now;
  logic [LANES-1:0]   lane_we;
  logic [BURST_W-1:0] lsb_cur;
  logic [BURST_W-1:0] lsb_adv;
  logic [ADDR_W-1:0]  cur_addr;
  logic [DATA_W-1:0]  rd_word;
  logic               drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Static mode pins, loaded with their open-pin values during reset.

  always_ff @(posedge clk)
  begin
    if (srst)
      mode_reg <= MODE_DEFAULT;
    else
      mode_reg <= mode;
  end

  assign sleeping   = mode_reg.sleep_req;
  assign pipelined  = mode_reg.flow_through_n;
  assign dual_cycle = !mode_reg.deselect_mode_sel;
  assign interleave = mode_reg.burst_order_linear_n;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      high_drive_reg <= !DEF_DRIVE_STRENGTH_SEL;
      standby_reg    <= DEF_SLEEP_REQ;
    end
    else
    begin
      high_drive_reg <= !mode_reg.drive_strength_sel;
      standby_reg    <= sleeping;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode. The processor strobe only counts with the first
  // enable low, and then it wins over the controller strobe.

  assign selected = !ctrl.chip_sel_first_n && ctrl.chip_sel_second
                    && !ctrl.chip_sel_third_n;
  assign cpu_go   = !ctrl.cpu_addr_strobe_n
                    && !ctrl.chip_sel_first_n;
  assign ctrl_go  = !cpu_go && !ctrl.ctrl_addr_strobe_n;

  assign begin_now = !sleeping && (cpu_go || ctrl_go) && selected;
  assign desel_now = !sleeping && (cpu_go || ctrl_go) && !selected;
  assign cont_now  = !sleeping && !cpu_go && ctrl.ctrl_addr_strobe_n
                     && (state_reg != ST_IDLE);
  assign adv_now   = cont_now && !ctrl.burst_advance_n;

  // The first cycle of a burst opened by the processor strobe is always a read.
  assign write_req = !wr.write_all_n || !wr.byte_write_gate_n;
  assign write_now = (begin_now && ctrl_go && write_req)
                     || (cont_now && write_req);
  assign read_now  = (begin_now && !write_now)
                     || (cont_now && !write_req);

  always_comb
  begin
    if (!wr.write_all_n)
      lane_we = '1;
    else if (!wr.byte_write_gate_n)
      lane_we = ~wr.lane_write_n;
    else
      lane_we = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst state.

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_READ, ST_WRITE:
      begin
        if (begin_now)
          state_next = write_now ? ST_WRITE : ST_READ;
        else if (desel_now)
          state_next = ST_IDLE;
        else if (cont_now)
          state_next = write_req ? ST_WRITE : ST_READ;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      base_reg <= '0;
    else if (begin_now)
      base_reg <= addr;
  end

  ssbc_burst_ctr u_burst
  (
    .clk        (clk),
    .srst       (srst),
    .load       (begin_now),
    .advance    (adv_now),
    .interleave (interleave),
    .start      (addr[BURST_W-1:0]),
    .lsb_cur    (lsb_cur),
    .lsb_adv    (lsb_adv)
  );

  // A new address is used at once; an advance uses the step, a held burst the current LSBs.
  always_comb
  begin
    if (begin_now)
      cur_addr = addr;
    else if (adv_now)
      cur_addr = {base_reg[ADDR_W-1:BURST_W], lsb_adv};
    else
      cur_addr = {base_reg[ADDR_W-1:BURST_W], lsb_cur};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and the data path.

  assign rd_word = mem[cur_addr];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (write_now && lane_we[i])
        mem[cur_addr][i*LANE_W +: LANE_W] <=
          data_lane_in[i*LANE_W +: LANE_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_q1_reg    <= '0;
      data_out_reg <= '0;
    end
    else
    begin
      rd_q1_reg    <= rd_word;
      data_out_reg <= pipelined ? rd_q1_reg : rd_word;
    end
  end

  // Drivers stay off during writes, standby and output enable high.
  ssbc_drive_ctl u_drive
  (
    .clk        (clk),
    .srst       (srst),
    .read_now   (read_now),
    .desel_now  (desel_now),
    .pipelined  (pipelined),
    .dual_cycle (dual_cycle),
    .gate       (!out_enable_n && !write_now && !sleeping),
    .drive_reg  (drive_reg)
  );

  assign data_lane_out = data_out_reg;
  assign data_lane_oe  = {LANES{drive_reg}};
  assign high_drive    = high_drive_reg;
  assign standby       = standby_reg;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_flow_read;
    !pipelined && read_now && !out_enable_n && !sleeping;
  endsequence

  sequence s_pipe_read;
    pipelined && read_now;
  endsequence

  a_write_hiz: assert property (
    write_now |=> (data_lane_oe == '0))
    else $error("lanes driven during a write");

  a_oe_high_off: assert property (
    out_enable_n |=> (data_lane_oe == '0))
    else $error("drivers on with output enable high");

  a_flow_read: assert property (
    s_flow_read |=> (data_lane_oe == '1)
      && (data_lane_out == $past(rd_word)))
    else $error("flow-through read data not presented");

  a_pipe_read: assert property (
    s_pipe_read ##1 pipelined |=> (data_lane_out == $past(rd_word, 2)))
    else $error("pipelined read data not one stage late");

  a_burst_load: assert property (
    begin_now |=> (lsb_cur == $past(addr[BURST_W-1:0])))
    else $error("burst counter not preset from address");

  a_burst_hold: assert property (
    (!begin_now && !adv_now) |=> $stable(lsb_cur))
    else $error("burst counter moved without advance");

  a_deselect_idle: assert property (
    desel_now |=> (state_reg == ST_IDLE) && (data_lane_oe == '0
      || (pipelined && dual_cycle)))
    else $error("deselect did not end the burst");

  a_global_write: assert property (
    (write_now && !wr.write_all_n) |-> (lane_we == '1) ##1 !drive_reg)
    else $error("global write missed a lane");

  a_sleep_quiet: assert property (
    sleeping |-> !read_now && !write_now ##1 !drive_reg)
    else $error("command taken in standby");

  a_reset_defaults: assert property (
    $past(srst) |-> (mode_reg == MODE_DEFAULT) && !high_drive
      && !standby && (data_lane_oe == '0))
    else $error("open-pin defaults not in force after reset");

  a_ctrl_strobe: assert property (
    (!sleeping && selected && ctrl.cpu_addr_strobe_n
      && !ctrl.ctrl_addr_strobe_n) |-> begin_now)
    else $error("controller strobe low did not start a burst");

  a_cpu_strobe: assert property (
    (!sleeping && selected && !ctrl.cpu_addr_strobe_n)
      |-> begin_now && read_now)
    else $error("processor strobe low did not start a read");

  a_begin_select: assert property (
    begin_now |-> !ctrl.chip_sel_first_n && ctrl.chip_sel_second
      && !ctrl.chip_sel_third_n)
    else $error("burst started while not selected");

  a_adv_next: assert property (
    adv_now |=> (lsb_cur == $past(lsb_adv)))
    else $error("advance did not step the burst address");

  a_lane_map: assert property (
    (write_now && wr.write_all_n) |-> (lane_we == ~wr.lane_write_n))
    else $error("lane write did not reach its own lane");

  a_no_lane_write: assert property (
    (write_now && wr.write_all_n && (wr.lane_write_n == '1))
      |-> (lane_we == '0))
    else $error("write with no lanes selected wrote a lane");

  a_read_decode: assert property (
    (begin_now && ctrl_go && wr.write_all_n && wr.byte_write_gate_n)
      |-> read_now && !write_now)
    else $error("read cycle decoded as a write");

  a_standby_off: assert property (
    sleeping |=> standby && (data_lane_oe == '0))
    else $error("standby left drivers on");

endmodule : ssbc_top
